// *** hdl/imups_pkg.sv ***
// constants, field layouts and types of the imu power-mode sequencer
//
// Notes on behaviour
// - With the fifo on and any sensor running, temperature samples are pushed too unless temperature is disabled.
// - In accelerometer-only low-noise mode the first sample after wake from sleep comes after 1 ms, whatever the rate.
// - In accelerometer low-power mode a new sample-rate divider applies after at most one sample at the old rate.
// - Leaving a low-power mode for low-noise may give unsettled samples; the host should pick the widest filter.
// - Going from gyro duty-cycled mode to gyro standby with the accelerometer off also turns the temperature sensor off.
// - After the duty-cycle bit is set the gyro moves from low-noise to low-power within one output-rate period.
// - If duty-cycle is already set at gyro turn-on, the first sample is low-noise and may be unsettled; discard it.
// - With auto-select the master clock is the gyro clock while the gyro is on, else the oscillator when awake.
// - When the gyro turns off and the part stays awake, the master clock hands over to the oscillator in about 20 us.
// - Sleep is entered only by writing the sleep bit to 1, never as a side effect of other settings.
// - With sleep clear but all six axis-disable bits set, both sensors power down and the master clock keeps running.
// - The fifo stays usable in every power mode, low-power modes included, with no special host action.
package imups_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ          = 20_000_000;
  localparam int CLK_SWITCH_US     = 20;
  localparam int CLK_SWITCH_CYCLES = (CLK_SWITCH_US * (CLOCK_HZ / 1_000_000) > 0) ?
                                     CLK_SWITCH_US * (CLOCK_HZ / 1_000_000) : 1;
  localparam int WAKE_DELAY_US     = 1000;
  localparam int WAKE_DELAY_CYCLES = WAKE_DELAY_US * (CLOCK_HZ / 1_000_000);
  localparam int BASE_RATE_HZ      = 1000;
  localparam int BASE_RATE_CYCLES  = CLOCK_HZ / BASE_RATE_HZ;
  localparam int COUNT_W           = 16;
  localparam int SWITCH_W          = 9;

  // ----------------------------------------------------------------
  // register map (byte addresses on apb)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_POWER_ONE   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_POWER_TWO   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_RATE_DIV    = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL   = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 12'h010;

  localparam logic [2:0] CLKSEL_AUTO   = 3'h1;
  localparam logic [2:0] AXES_ALL_OFF  = 3'h7;

  // power_control_one: [0] sleep, [3:1] clock_source_select, [4] temperature disable
  typedef struct packed {
    logic       temp_disable;
    logic [2:0] clock_source_select;
    logic       sleep;
  } imups_power_one_type;
  localparam int POWER_ONE_W = 5;
  localparam logic [POWER_ONE_W-1:0] POWER_ONE_RESET = 5'h01;

  // power_control_two: [2:0] accel axis disable, [5:3] gyro axis disable, [6] duty, [7] standby, [8] accel lp
  typedef struct packed {
    logic       accel_low_power;
    logic       gyro_standby;
    logic       gyro_duty_cycle;
    logic [2:0] gyro_axis_disable;
    logic [2:0] accel_axis_disable;
  } imups_power_two_type;
  localparam int POWER_TWO_W = 9;
  localparam logic [POWER_TWO_W-1:0] POWER_TWO_RESET = 9'h000;

  localparam logic [7:0] RATE_DIV_RESET = 8'h00;

  // status: one bit each
  typedef struct packed {
    logic wake_wait;
    logic unsettled_pending;
    logic accel_on;
    logic gyro_low_power;
    logic gyro_on;
    logic temp_on;
    logic clock_switching;
    logic clock_is_gyro;
    logic sleeping;
  } imups_status_type;
  localparam int STATUS_W = 9;

  // fifo push strobes for one sample event
  typedef struct packed {
    logic temp;
    logic gyro;
    logic accel;
  } imups_push_type;

  // ----------------------------------------------------------------
  // gyroscope mode states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    GYRO_OFF        = 5'b00001,
    GYRO_LOW_NOISE  = 5'b00010,
    GYRO_SWITCH_LP  = 5'b00100,
    GYRO_LOW_POWER  = 5'b01000,
    GYRO_STANDBY    = 5'b10000
  } imups_gyro_state_type;

endpackage : imups_pkg

// *** hdl/imups_odr_timer.sv ***
// output-data-rate pacing: base-rate divider with a sample-rate divider latched per sample
`timescale 1ns/1ns
module imups_odr_timer
  import imups_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_RATE_CYCLES
)
(
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [7:0] divider_i,
  output logic            sample_tick_o
);

  logic [COUNT_W-1:0] base_cnt;
  logic [7:0]         div_cnt;
  logic [7:0]         div_active;
  logic               base_tick;
  logic               sample_hit;

  assign base_tick  = (base_cnt == COUNT_W'(BASE_CYCLES - 1));
  assign sample_hit = base_tick && (div_cnt == div_active);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      base_cnt <= '0;
    else if (!run_i || restart_i || base_tick)
      base_cnt <= '0;
    else
      base_cnt <= base_cnt + COUNT_W'(1);
  end

  // divider is taken at a sample boundary, at a restart or while stopped, so a new value waits out the running period
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_cnt    <= '0;
      div_active <= RATE_DIV_RESET;
    end
    else if (!run_i || restart_i || sample_hit)
    begin
      div_cnt    <= '0;
      div_active <= divider_i;
    end
    else if (base_tick)
      div_cnt <= div_cnt + 8'h01;
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sample_tick_o <= 1'b0;
    else
      sample_tick_o <= run_i && !restart_i && sample_hit;
  end

endmodule : imups_odr_timer

// *** hdl/imups_sequencer.sv ***
// imu power-mode and clock-source sequencer with apb register slave
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module imups_sequencer
  import imups_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_RATE_CYCLES,
  parameter int WAKE_CYCLES = WAKE_DELAY_CYCLES
)
(
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   gyro_power_o,
  output logic                   accel_power_o,
  output logic                   temp_power_o,
  output logic                   osc_enable_o,
  output logic                   master_clock_gyro_o,
  output logic                   clock_switching_o,
  output logic                   sample_strobe_o,
  output imups_push_type         fifo_push_o,
  output logic                   sample_unsettled_o
);

  // ----------------------------------------------------------------
  // registers and apb slave
  // ----------------------------------------------------------------
  imups_power_one_type  power_control_one;
  imups_power_two_type  power_control_two;
  logic [7:0]           sample_rate_divider;
  logic                 fifo_enable;
  imups_status_type     status;
  logic                 setup_phase;
  logic                 access_write;
  logic                 addr_bad;
  logic [31:0]          next_prdata;
  logic                 next_addr_bad;

  assign setup_phase  = psel_i && !penable_i;
  assign access_write = psel_i && penable_i && pwrite_i;
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i && penable_i && addr_bad;

  always_comb
  begin
    next_prdata   = 32'h0000_0000;
    next_addr_bad = 1'b0;
    if (paddr_i == ADDR_POWER_ONE)
      next_prdata = {{(32-POWER_ONE_W){1'b0}}, power_control_one};
    else if (paddr_i == ADDR_POWER_TWO)
      next_prdata = {{(32-POWER_TWO_W){1'b0}}, power_control_two};
    else if (paddr_i == ADDR_RATE_DIV)
      next_prdata = {24'h00_0000, sample_rate_divider};
    else if (paddr_i == ADDR_FIFO_CTRL)
      next_prdata = {31'h0000_0000, fifo_enable};
    else if (paddr_i == ADDR_STATUS)
      next_prdata = {{(32-STATUS_W){1'b0}}, status};
    else
      next_addr_bad = 1'b1;
  end

  // read data is captured in the setup cycle so the access phase needs no wait state
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
      addr_bad <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
      addr_bad <= next_addr_bad;
    end
  end

  // sleep changes only through this write path
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      power_control_one   <= POWER_ONE_RESET;
      power_control_two   <= POWER_TWO_RESET;
      sample_rate_divider <= RATE_DIV_RESET;
      fifo_enable         <= 1'b0;
    end
    else if (access_write && !addr_bad)
    begin
      if (paddr_i == ADDR_POWER_ONE)
        power_control_one <= imups_power_one_type'(pwdata_i[POWER_ONE_W-1:0]);
      else if (paddr_i == ADDR_POWER_TWO)
        power_control_two <= imups_power_two_type'(pwdata_i[POWER_TWO_W-1:0]);
      else if (paddr_i == ADDR_RATE_DIV)
        sample_rate_divider <= pwdata_i[7:0];
      else if (paddr_i == ADDR_FIFO_CTRL)
        fifo_enable <= pwdata_i[0];
    end
  end

  // ----------------------------------------------------------------
  // derived power requests
  // ----------------------------------------------------------------
  logic sleep;
  logic gyro_axes_on;
  logic accel_on;
  logic gyro_off_cond;
  logic sleep_q;
  logic wake;

  assign sleep         = power_control_one.sleep;
  assign gyro_axes_on  = (power_control_two.gyro_axis_disable != AXES_ALL_OFF);
  assign accel_on      = !sleep && (power_control_two.accel_axis_disable != AXES_ALL_OFF);
  // standby with every axis off is treated as gyro off
  assign gyro_off_cond = sleep || !gyro_axes_on;
  assign wake          = sleep_q && !sleep;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sleep_q <= 1'b1;
    else
      sleep_q <= sleep;
  end

  // ----------------------------------------------------------------
  // sample pacing
  // ----------------------------------------------------------------
  logic               sample_tick;
  logic               accel_wait;
  logic [COUNT_W-1:0] wake_cnt;
  logic               wake_done;
  logic               sample_evt;

  imups_odr_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_odr_timer (
    .clock_i       (clock_i),
    .arst_n_i      (arst_n_i),
    .run_i         (!sleep),
    .restart_i     (wake_done),
    .divider_i     (sample_rate_divider),
    .sample_tick_o (sample_tick)
  );

  assign wake_done  = accel_wait && (wake_cnt == COUNT_W'(WAKE_CYCLES - 1));
  assign sample_evt = (sample_tick && !accel_wait) || wake_done;

  // accel-only low-noise wake: first sample after a fixed delay, the rate timer restarts from it
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      accel_wait <= 1'b0;
      wake_cnt   <= '0;
    end
    else if (sleep || wake_done)
    begin
      accel_wait <= 1'b0;
      wake_cnt   <= '0;
    end
    else if (wake && accel_on && !power_control_two.accel_low_power && !gyro_axes_on)
    begin
      accel_wait <= 1'b1;
      wake_cnt   <= '0;
    end
    else if (accel_wait)
      wake_cnt <= wake_cnt + COUNT_W'(1);
  end

  // ----------------------------------------------------------------
  // gyroscope mode machine
  // ----------------------------------------------------------------
  imups_gyro_state_type gyro_state;
  imups_gyro_state_type next_gyro_state;
  logic                 first_pending;
  logic                 lp_recent;
  logic                 temp_kill;
  logic                 gyro_unsettled;
  logic                 accel_unsettled;
  logic                 accel_lp_q;
  logic                 gyro_sampling;
  logic                 enter_standby_from_lp;

  always_comb
  begin
    next_gyro_state = gyro_state;
    case (gyro_state)
      GYRO_OFF:
        if (!gyro_off_cond)
          next_gyro_state = GYRO_LOW_NOISE;
      GYRO_LOW_NOISE:
        if (gyro_off_cond)
          next_gyro_state = GYRO_OFF;
        else if (power_control_two.gyro_standby)
          next_gyro_state = GYRO_STANDBY;
        else if (power_control_two.gyro_duty_cycle && !first_pending)
          next_gyro_state = GYRO_SWITCH_LP;
      GYRO_SWITCH_LP:
        if (gyro_off_cond)
          next_gyro_state = GYRO_OFF;
        else if (power_control_two.gyro_standby)
          next_gyro_state = GYRO_STANDBY;
        else if (!power_control_two.gyro_duty_cycle)
          next_gyro_state = GYRO_LOW_NOISE;
        else if (sample_tick)
          next_gyro_state = GYRO_LOW_POWER;
      GYRO_LOW_POWER:
        if (gyro_off_cond)
          next_gyro_state = GYRO_OFF;
        else if (power_control_two.gyro_standby)
          next_gyro_state = GYRO_STANDBY;
        else if (!power_control_two.gyro_duty_cycle)
          next_gyro_state = GYRO_LOW_NOISE;
      GYRO_STANDBY:
        if (gyro_off_cond)
          next_gyro_state = GYRO_OFF;
        else if (!power_control_two.gyro_standby)
          next_gyro_state = power_control_two.gyro_duty_cycle ? GYRO_SWITCH_LP : GYRO_LOW_NOISE;
      default:
        next_gyro_state = GYRO_OFF;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      gyro_state <= GYRO_OFF;
    else
      gyro_state <= next_gyro_state;
  end

  assign gyro_sampling = (gyro_state == GYRO_LOW_NOISE) || (gyro_state == GYRO_SWITCH_LP) ||
                         (gyro_state == GYRO_LOW_POWER);
  // leaving duty-cycle less than one rate period ago still counts as coming from low power
  assign enter_standby_from_lp = (next_gyro_state == GYRO_STANDBY) && (gyro_state != GYRO_STANDBY) &&
                                 ((gyro_state == GYRO_LOW_POWER) || lp_recent);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      first_pending <= 1'b0;
      lp_recent     <= 1'b0;
    end
    else
    begin
      if (sample_tick || gyro_off_cond)
        first_pending <= 1'b0;
      if (sample_tick || gyro_off_cond)
        lp_recent <= 1'b0;
      if (gyro_state == GYRO_OFF && next_gyro_state == GYRO_LOW_NOISE)
        first_pending <= 1'b1;
      if (gyro_state == GYRO_LOW_POWER && next_gyro_state == GYRO_LOW_NOISE)
        lp_recent <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      temp_kill <= 1'b0;
    else if (enter_standby_from_lp && !accel_on)
      temp_kill <= 1'b1;
    else if (gyro_state != GYRO_STANDBY || accel_on)
      temp_kill <= 1'b0;
  end

  // unsettled markers: a set in the same cycle as the sample that clears them wins
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gyro_unsettled  <= 1'b0;
      accel_unsettled <= 1'b0;
      accel_lp_q      <= 1'b0;
    end
    else
    begin
      accel_lp_q <= power_control_two.accel_low_power;
      if (sample_evt || !gyro_sampling)
        gyro_unsettled <= 1'b0;
      if (sample_evt || !accel_on)
        accel_unsettled <= 1'b0;
      if (gyro_state == GYRO_OFF && next_gyro_state == GYRO_LOW_NOISE && power_control_two.gyro_duty_cycle)
        gyro_unsettled <= 1'b1;
      if (gyro_state == GYRO_LOW_POWER && next_gyro_state == GYRO_LOW_NOISE)
        gyro_unsettled <= 1'b1;
      if (accel_lp_q && !power_control_two.accel_low_power && accel_on)
        accel_unsettled <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // master clock selection
  // ----------------------------------------------------------------
  logic                gyro_clk_target;
  logic [SWITCH_W-1:0] switch_cnt;
  logic                switch_done;

  assign gyro_clk_target = (power_control_one.clock_source_select == CLKSEL_AUTO) &&
                           (gyro_state != GYRO_OFF);
  assign switch_done     = clock_switching_o && (switch_cnt == SWITCH_W'(CLK_SWITCH_CYCLES - 1));

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      master_clock_gyro_o <= 1'b0;
      clock_switching_o   <= 1'b0;
      switch_cnt          <= '0;
    end
    else if (sleep)
    begin
      master_clock_gyro_o <= 1'b0;
      clock_switching_o   <= 1'b0;
      switch_cnt          <= '0;
    end
    else if (master_clock_gyro_o && !gyro_clk_target)
    begin
      // gyro clock stays selected until the oscillator has taken over
      clock_switching_o <= !switch_done;
      switch_cnt        <= clock_switching_o ? switch_cnt + SWITCH_W'(1) : '0;
      if (switch_done)
        master_clock_gyro_o <= 1'b0;
    end
    else
    begin
      master_clock_gyro_o <= gyro_clk_target;
      clock_switching_o   <= 1'b0;
      switch_cnt          <= '0;
    end
  end

  assign osc_enable_o = !sleep && (!master_clock_gyro_o || clock_switching_o);

  // ----------------------------------------------------------------
  // power enables, fifo pushes and status
  // ----------------------------------------------------------------
  logic temp_on;

  assign temp_on = (accel_on || gyro_state != GYRO_OFF) && !power_control_one.temp_disable && !temp_kill;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gyro_power_o  <= 1'b0;
      accel_power_o <= 1'b0;
      temp_power_o  <= 1'b0;
    end
    else
    begin
      gyro_power_o  <= (gyro_state != GYRO_OFF);
      accel_power_o <= accel_on;
      temp_power_o  <= temp_on;
    end
  end

  // no power-mode gating on the fifo path
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sample_strobe_o    <= 1'b0;
      fifo_push_o        <= '0;
      sample_unsettled_o <= 1'b0;
    end
    else
    begin
      sample_strobe_o    <= sample_evt;
      fifo_push_o.accel  <= fifo_enable && accel_on && sample_evt;
      fifo_push_o.gyro   <= fifo_enable && gyro_sampling && sample_tick && !accel_wait;
      fifo_push_o.temp   <= fifo_enable && temp_on && (accel_on || gyro_sampling) && sample_evt;
      sample_unsettled_o <= sample_evt && ((gyro_unsettled && gyro_sampling) || (accel_unsettled && accel_on));
    end
  end

  assign status.sleeping          = sleep;
  assign status.clock_is_gyro     = master_clock_gyro_o;
  assign status.clock_switching   = clock_switching_o;
  assign status.temp_on           = temp_on;
  assign status.gyro_on           = (gyro_state != GYRO_OFF);
  assign status.gyro_low_power    = (gyro_state == GYRO_LOW_POWER);
  assign status.accel_on          = accel_on;
  assign status.unsettled_pending = gyro_unsettled || accel_unsettled;
  assign status.wake_wait         = accel_wait;

endmodule : imups_sequencer

// *** testbench/imups_properties.sv ***
// checker for the sequencer's power, clock and sample outputs
`timescale 1ns/1ns
module imups_properties
  import imups_pkg::*;
(
  input wire logic           clock_i,
  input wire logic           arst_n_i,
  input wire logic           gyro_power_o,
  input wire logic           osc_enable_o,
  input wire logic           master_clock_gyro_o,
  input wire logic           clock_switching_o,
  input wire logic           sample_strobe_o,
  input wire logic           sample_unsettled_o,
  input wire imups_push_type fifo_push_o
);
  logic [9:0] sw_cnt;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sw_cnt <= 10'h000;
    else if (clock_switching_o)
      sw_cnt <= sw_cnt + 10'h001;
    else
      sw_cnt <= 10'h000;
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_switch_done;
    $fell(clock_switching_o) && osc_enable_o;
  endsequence

  chk_push_strobe: assert property (|fifo_push_o |-> sample_strobe_o)
    else $error("fifo push without sample");
  chk_temp_sensor: assert property (fifo_push_o.temp |-> fifo_push_o.accel || fifo_push_o.gyro)
    else $error("temperature pushed alone");
  chk_unsettled_mark: assert property (sample_unsettled_o |-> sample_strobe_o)
    else $error("unsettled mark without sample");
  chk_switch_length: assert property (s_switch_done |-> sw_cnt == 10'h190)
    else $error("clock handover length wrong");
  chk_switch_osc: assert property (s_switch_done |-> ##[0:1] !master_clock_gyro_o)
    else $error("master clock kept on gyro");
  chk_switch_start: assert property ($rose(clock_switching_o) |-> !gyro_power_o ##0 master_clock_gyro_o[*4])
    else $error("handover started wrongly");
  chk_gyro_clock: assert property (master_clock_gyro_o |-> gyro_power_o || clock_switching_o || $past(gyro_power_o))
    else $error("gyro clock without gyro");
  chk_no_sleep_sample: assert property (sample_strobe_o |-> $past(osc_enable_o) || $past(master_clock_gyro_o))
    else $error("sample while asleep");
  chk_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe too long");
endmodule : imups_properties

bind imups_sequencer imups_properties i_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .gyro_power_o(gyro_power_o), .osc_enable_o(osc_enable_o),
  .master_clock_gyro_o(master_clock_gyro_o), .clock_switching_o(clock_switching_o),
  .sample_strobe_o(sample_strobe_o), .sample_unsettled_o(sample_unsettled_o), .fifo_push_o(fifo_push_o));

// *** testbench/imups_host_model.sv ***
// apb host that programs the sequencer's registers
`timescale 1ns/1ns
module imups_host_model
  import imups_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         pready_i,
  input  wire logic         pslverr_i,
  input  wire logic [31:0]  prdata_i,
  output logic              psel_o,
  output logic              penable_o,
  output logic              pwrite_o,
  output logic [ADDR_W-1:0] paddr_o,
  output logic [31:0]       pwdata_o
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end

  // request held until pready; bounded so a stuck slave cannot hang the run
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    int k;
    k = 0;
    @(posedge clock_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (pready_i !== 1'b1 && k < 16);
    q = prdata_i;
    e = pslverr_i;
    t = (pready_i !== 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : imups_host_model

// *** testbench/testbench.sv ***
// self-checking bench for the power-mode sequencer
`timescale 1ns/1ns
module testbench
  import imups_pkg::*;
;
  localparam int BASE_C = 20;
  localparam int WAKE_C = 30;
  logic              clock_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              psel, penable, pwrite, pready, pslverr, err;
  logic              gyro_pw, accel_pw, temp_pw, osc_en, mclk_gyro, clk_sw, strobe, unsettled;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  imups_push_type    push;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                n;

  always #25 clock_i = ~clock_i;

  imups_host_model i_host (.clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  imups_sequencer #(.BASE_CYCLES(BASE_C), .WAKE_CYCLES(WAKE_C)) i_dut (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .gyro_power_o(gyro_pw),
    .accel_power_o(accel_pw), .temp_power_o(temp_pw), .osc_enable_o(osc_en), .master_clock_gyro_o(mclk_gyro),
    .clock_switching_o(clk_sw), .sample_strobe_o(strobe), .fifo_push_o(push), .sample_unsettled_o(unsettled));

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic t;
    i_host.xfer(w, a, d, rd, err, t);
    if (t)
    begin
      n_mismatch++;
      test_done();
    end
  endtask : bus

  // counts falling edges until a sample shows
  task automatic wait_strobe(output int k);
    k = 0;
    do
    begin
      @(negedge clock_i);
      k++;
    end
    while (strobe !== 1'b1 && k < 2000);
    if (k >= 2000)
    begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_strobe

  initial
  begin
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    bus(1'b0, ADDR_POWER_ONE, 32'h0);
    chk("power one", 32'h1, rd);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    bus(1'b1, ADDR_FIFO_CTRL, 32'h1);
    bus(1'b1, ADDR_POWER_TWO, 32'h38);
    bus(1'b1, ADDR_POWER_ONE, 32'h2);
    wait_strobe(n);
    chk("wake delay", WAKE_C + 2, n);
    chk("push", 32'h5, {29'h0, push});
    chk("clocks", 32'h1, {30'h0, mclk_gyro, osc_en});
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    bus(1'b1, ADDR_POWER_TWO, 32'h138);
    bus(1'b1, ADDR_RATE_DIV, 32'h2);
    repeat (3) wait_strobe(n);
    chk("new rate", 3 * BASE_C, n);
    bus(1'b1, ADDR_POWER_TWO, 32'h3F);
    repeat (3) @(negedge clock_i);
    chk("all off", 32'h1, {29'h0, gyro_pw, accel_pw, osc_en});
    bus(1'b1, ADDR_POWER_TWO, 32'h7);
    repeat (BASE_C + 3) @(negedge clock_i);
    chk("gyro clock", 32'h3, {30'h0, gyro_pw, mclk_gyro});
    bus(1'b1, ADDR_POWER_TWO, 32'h87);
    repeat (3) @(negedge clock_i);
    chk("temp kept", 32'h3, {30'h0, gyro_pw, temp_pw});
    bus(1'b1, ADDR_POWER_TWO, 32'h7);
    bus(1'b1, ADDR_POWER_TWO, 32'h47);
    repeat (2) wait_strobe(n);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("low power", 32'h1, {31'h0, rd[5]});
    bus(1'b1, ADDR_POWER_TWO, 32'h7);
    wait_strobe(n);
    chk("unsettled", 32'h1, {31'h0, unsettled});
    bus(1'b1, ADDR_POWER_TWO, 32'h47);
    repeat (2) wait_strobe(n);
    bus(1'b1, ADDR_POWER_TWO, 32'hC7);
    repeat (3) @(negedge clock_i);
    chk("temp off", 32'h2, {30'h0, gyro_pw, temp_pw});
    bus(1'b1, ADDR_POWER_TWO, 32'h47);
    bus(1'b1, ADDR_POWER_TWO, 32'h7F);
    repeat (3) @(negedge clock_i);
    chk("switching", 32'h1, {31'h0, clk_sw});
    n = 0;
    while (mclk_gyro !== 1'b0 && n < 600)
    begin
      @(negedge clock_i);
      n++;
    end
    chk("handover", 32'h1, {30'h0, mclk_gyro, osc_en});
    chk("handover time", 32'h1, {31'h0, n > 385 && n < 402});
    bus(1'b1, ADDR_POWER_TWO, 32'h47);
    wait_strobe(n);
    if (!push.gyro)
      wait_strobe(n);
    chk("first sample", 32'h3, {30'h0, push.gyro, unsettled});
    bus(1'b1, ADDR_POWER_TWO, 32'h0);
    bus(1'b1, ADDR_POWER_ONE, 32'h3);
    repeat (3) @(negedge clock_i);
    chk("asleep", 32'h0, {29'h0, gyro_pw, mclk_gyro, osc_en});
    test_done();
  end
endmodule : testbench
